// ---- sim/lsp_host_model.sv ----
`timescale 1ns/1ps
// Host serial master, mode 0, one frame per call
module lsp_host_model (
    input  wire logic ref_clk_i,  // Bench clock
    input  wire logic spi_miso_i, // Resolved data out
    output logic      spi_cs_n_o, // Chip select, low
    output logic      spi_sclk_o, // Serial clock
    output logic      spi_mosi_o  // Serial data in
);
    // Idle: deselected, clock parked low
    initial begin
        spi_cs_n_o = 1'b1;
        spi_sclk_o = 1'b0;
        spi_mosi_o = 1'b0;
    end

    // Shifts nb bits MSB first; lo sets the low phase, so slow hosts too
    task automatic xfer(input logic [31:0] cmd, input int nb, input int lo, output logic [31:0] rsp);
        rsp = '0;
        @(posedge ref_clk_i) spi_cs_n_o <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        for (int i = 31; i > 31 - nb; i--) begin
            spi_mosi_o <= cmd[i];
            repeat (lo) @(posedge ref_clk_i);
            rsp[i] = spi_miso_i;
            spi_sclk_o <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            spi_sclk_o <= 1'b0;
        end
        repeat (4) @(posedge ref_clk_i);
        spi_cs_n_o <= 1'b1;
        spi_mosi_o <= ~spi_mosi_o; // Data is stale outside a frame
        repeat (8) @(posedge ref_clk_i);
    endtask : xfer
endmodule : lsp_host_model

// ---- sim/test_lpm_slow_poll_debounce_regs.sv ----
`timescale 1ns/1ps
module test_lpm_slow_poll_debounce_regs;
    import lsp_pkg::*;
    typedef struct packed {
        logic [6:0]  addr;
        logic [23:0] wdata;
        logic [23:0] exp;
        logic        flt;
        logic        irq;
    } lsp_row_t;
    localparam int POLL = 4;
    localparam int DEB  = 20;
    // Written value beside the masked value it should read back
    localparam lsp_row_t ROWS [5] = '{
        '{ADDR_SLOW_PROG, 24'hff_ffff, 24'h00_0fff, 1'b1, 1'b0},
        '{ADDR_SLOW_GND,  24'hfe_8001, 24'h1e_0001, 1'b0, 1'b1},
        '{ADDR_DEB_PROG,  24'hab_c001, 24'h00_0001, 1'b1, 1'b1},
        '{7'h1b,          24'h12_3456, 24'h00_0000, 1'b0, 1'b0},
        '{ADDR_SLOW_PROG, 24'hff_f002, 24'h00_0002, 1'b0, 1'b0}};
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, flt = 1'b0, irq = 1'b0, lpm = 1'b0, tick = 1'b0;
    logic cs_n, sclk, mosi, miso, oe_n, miso_last = 1'b0;
    logic [NUM_CH-1:0]   strobe;
    logic [NUM_PROG-1:0] src, judge;
    logic [31:0] rsp, exp_next = '0;
    int bad_count = 0, check_count = 0, n_str [4] = '{0, 0, 0, 0}, n_src0 = 0, n_src2 = 0;
    wire miso_w = oe_n ? ~miso_last : miso; // Released line shows no old value

    always #4 ref_clk_i = ~ref_clk_i;

    lsp_regs #(.POLL_ON_CYC(POLL), .DEB_CYC(DEB)) i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_n_o(oe_n), .fault_status_i(flt), .interrupt_flag_i(irq),
        .low_power_mode_i(lpm), .poll_tick_i(tick), .poll_strobe_o(strobe),
        .prog_source_o(src), .prog_final_judge_o(judge));
    lsp_host_model i_host (.ref_clk_i(ref_clk_i), .spi_miso_i(miso_w), .spi_cs_n_o(cs_n),
        .spi_sclk_o(sclk), .spi_mosi_o(mosi));

    // Remember the last driven bit and count polling activity
    always @(posedge ref_clk_i) begin
        if (!oe_n) miso_last <= miso;
        if (nrst_i) begin
            n_str[0] += int'(strobe[0]);
            n_str[1] += int'(strobe[1]);
            n_str[2] += int'(strobe[NUM_PROG]);
            n_str[3] += int'(strobe[NUM_PROG+1]);
            n_src0 += int'(src[0]);
            n_src2 += int'(src[2]);
        end
    end

    task automatic chk_rsp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %0t word %h want %h", $time, got, exp);
        end
    endtask : chk_rsp

    task automatic chk_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            bad_count++;
            $display("unexpected %0t count %0d want %0d", $time, got, exp);
        end
    endtask : chk_cnt

    // One frame; checks the answer to the previous one, flags from this one
    task automatic frame(input logic [31:0] cmd, input int nb, input int lo, input logic [31:0] nxt);
        i_host.xfer(cmd, nb, lo, rsp);
        chk_rsp(rsp, exp_next | {8'h00, flt, irq, 22'h0});
        exp_next = nxt;
    endtask : frame

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Watchdog well beyond the expected run
    initial begin
        #(8 * 40000);
        bad_count++;
        $display("unexpected %0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (16) @(posedge ref_clk_i);
        chk_rsp({29'h0, miso, |{strobe, src, judge}, oe_n}, 32'h1);
        nrst_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        // Reset values through read frames
        frame({ADDR_SLOW_PROG, 1'b0, 24'h0}, 32, 6, {ADDR_SLOW_PROG, 25'h0});
        frame({ADDR_SLOW_GND, 1'b0, 24'h0}, 32, 6, {ADDR_SLOW_GND, 25'h0});
        frame({ADDR_DEB_PROG, 1'b0, 24'h0}, 32, 12, {ADDR_DEB_PROG, 25'h0});
        // Write then read back each row
        foreach (ROWS[r]) begin
            flt <= ROWS[r].flt;
            irq <= ROWS[r].irq;
            frame({ROWS[r].addr, RW_WRITE, ROWS[r].wdata}, 32, 6,
                  {ROWS[r].addr, RW_WRITE, 2'b00, ROWS[r].exp[21:0]});
            frame({ROWS[r].addr, 1'b0, 24'h0}, 32, 12, {ROWS[r].addr, 1'b0, 2'b00, ROWS[r].exp[21:0]});
        end
        // Short frame must be ignored
        frame({ADDR_SLOW_PROG, RW_WRITE, 24'hff_ffff}, 31, 6, {ADDR_SLOW_PROG, 1'b0, 24'h2});
        frame({ADDR_SLOW_PROG, 1'b0, 24'h0}, 32, 6, '0);
        // Low power polling: ch1 and ground ch0 slow, ch0 debounced
        lpm <= 1'b1;
        for (int t = 0; t < 8; t++) begin
            tick <= 1'b1;
            @(posedge ref_clk_i) tick <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            if (t == 0) chk_rsp({30'h0, judge[0], judge[2]}, 32'h2);
            repeat (36) @(posedge ref_clk_i);
        end
        lpm <= 1'b0;
        @(posedge ref_clk_i) tick <= 1'b1;
        @(posedge ref_clk_i) tick <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        chk_cnt(n_str[0], 8);
        chk_cnt(n_str[1], 2);
        chk_cnt(n_str[2], 2);
        chk_cnt(n_str[3], 8);
        chk_cnt(n_src0, 8 * (POLL + DEB));
        chk_cnt(n_src2, 8 * POLL);
        // Reset in mid-run clears outputs, judge mode and registers
        nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk_rsp({29'h0, miso, |{strobe, src, judge}, oe_n}, 32'h1);
        nrst_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        exp_next = '0;
        frame({ADDR_SLOW_GND, 1'b0, 24'h0}, 32, 6, {ADDR_SLOW_GND, 25'h0});
        frame({ADDR_SLOW_PROG, 1'b0, 24'h0}, 32, 6, '0);
        results();
    end
endmodule : test_lpm_slow_poll_debounce_regs

// ---- verilog/lsp_cfg_if.sv ----
`timescale 1ns/1ps
interface lsp_cfg_if;
    logic [11:0] slow_prog;
    logic [20:0] slow_gnd;
    logic [11:0] deb_prog;
    modport regs  (output slow_prog, slow_gnd, deb_prog);
    modport sched (input  slow_prog, slow_gnd, deb_prog);
endinterface : lsp_cfg_if

// ---- verilog/lsp_pkg.sv ----
package lsp_pkg;
    // Frame layout
    localparam int          FRAME_BITS  = 32;
    localparam int          BIT_CNT_W   = 6;
    localparam int          ADDR_MSB    = 31;
    localparam int          ADDR_LSB    = 25;
    localparam int          RW_BIT      = 24;
    localparam int          FAULT_BIT   = 23;
    localparam int          INT_BIT     = 22;
    localparam int          DATA_W      = 24;
    localparam int          RESP_DATA_W = 22;
    localparam logic [BIT_CNT_W-1:0] FRAME_LEN  = 6'h20;
    localparam logic [BIT_CNT_W-1:0] FRAME_OVER = 6'h21;
    localparam logic                 RW_WRITE   = 1'b1;

    // Register map
    localparam logic [6:0]  ADDR_SLOW_PROG = 7'h18;
    localparam logic [6:0]  ADDR_SLOW_GND  = 7'h19;
    localparam logic [6:0]  ADDR_DEB_PROG  = 7'h1a;
    localparam logic [DATA_W-1:0] MASK_PROG  = 24'h00_0fff;
    localparam logic [DATA_W-1:0] MASK_GND   = 24'h1f_7fff;
    localparam logic [DATA_W-1:0] RESET_VAL  = 24'h00_0000;

    // Channel counts
    localparam int          NUM_PROG = 12;
    localparam int          NUM_GND  = 21;
    localparam int          NUM_CH   = NUM_PROG + NUM_GND;

    // Slow polling divides the base tick by four
    localparam int          SLOW_CNT_W  = 2;
    localparam logic [SLOW_CNT_W-1:0] SLOW_PHASE0 = 2'h0;
    localparam logic [SLOW_CNT_W-1:0] SLOW_STEP   = 2'h1;

    // Sourcing timing
    localparam int          CLK_FREQ_MHZ    = 125;
    localparam int          DEB_TIME_US     = 1200;
    localparam int          DEB_CYC_DEF     = DEB_TIME_US * CLK_FREQ_MHZ;
    localparam int          POLL_ON_CYC_DEF = 16;
    localparam int          TMR_W           = 18;
    localparam logic [TMR_W-1:0] TMR_ZERO   = 18'h0_0000;
endpackage : lsp_pkg

// ---- verilog/lsp_poll_sched.sv ----
`timescale 1ns/1ps
module lsp_poll_sched
    import lsp_pkg::*;
#(
    parameter int POLL_ON_CYC = POLL_ON_CYC_DEF,
    parameter int DEB_CYC     = DEB_CYC_DEF
) (
    input  wire logic                ref_clk_i,   // System clock
    input  wire logic                nrst_i,      // Async reset, low
    lsp_cfg_if.sched                 cfg,         // Configuration bits
    input  wire logic                lpm_i,       // Low power mode active
    input  wire logic                tick_i,      // Base polling tick
    output logic [NUM_CH-1:0]        poll_o,      // Per-channel poll pulse
    output logic [NUM_PROG-1:0]      source_o,    // Polling current on
    output logic [NUM_PROG-1:0]      final_o      // Judge final voltage
);
    localparam logic [TMR_W-1:0] ON_T  = TMR_W'(POLL_ON_CYC);
    localparam logic [TMR_W-1:0] EXT_T = TMR_W'(POLL_ON_CYC + DEB_CYC);

    logic [NUM_CH-1:0] slow_vec;
    assign slow_vec = {cfg.slow_gnd, cfg.slow_prog};

    genvar g;
    // Per-channel poll divider
    for (g = 0; g < NUM_CH; g++) begin : g_ch
        logic [SLOW_CNT_W-1:0] phase_reg;
        logic                  poll_reg;
        always_ff @(posedge ref_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                phase_reg <= SLOW_PHASE0;
                poll_reg  <= 1'b0;
            end else begin
                poll_reg <= 1'b0;
                if (!lpm_i) begin
                    phase_reg <= SLOW_PHASE0;
                end else if (tick_i) begin
                    phase_reg <= phase_reg + SLOW_STEP;
                    poll_reg  <= !slow_vec[g] || (phase_reg == SLOW_PHASE0); // RL1 RL2
                end
            end
        end
        assign poll_o[g] = poll_reg; // One driver per output bit
        a_fast_poll: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
            lpm_i && tick_i && !slow_vec[g] |=> poll_o[g]) // RL1
            else $error("base rate channel missed its poll");
        a_slow_gap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
            lpm_i && tick_i && slow_vec[g] && phase_reg != SLOW_PHASE0 |=> !poll_o[g]) // RL2
            else $error("slow channel polled off its quarter phase");
    end

    // Sourcing timer per battery-programmable channel
    for (g = 0; g < NUM_PROG; g++) begin : g_src
        logic [TMR_W-1:0] tmr_reg;
        logic             judge_reg;
        always_ff @(posedge ref_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                tmr_reg   <= TMR_ZERO;
                judge_reg <= 1'b0;
            end else if (!lpm_i) begin
                tmr_reg   <= TMR_ZERO;
            end else if (poll_o[g]) begin
                tmr_reg   <= cfg.deb_prog[g] ? EXT_T : ON_T; // RL3 RL4
                judge_reg <= cfg.deb_prog[g];                // RL3 RL4
            end else if (tmr_reg != TMR_ZERO) begin
                tmr_reg <= tmr_reg - 1'b1;
            end
        end
        assign source_o[g] = (tmr_reg != TMR_ZERO);
        assign final_o[g]  = judge_reg;
        a_src_start: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
            lpm_i && poll_o[g] |=> source_o[g] && final_o[g] == $past(cfg.deb_prog[g])) // RL3
            else $error("polling current did not start with the right mode");
        a_deb_extend: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
            lpm_i && poll_o[g] && cfg.deb_prog[g] |=> tmr_reg == EXT_T) // RL4
            else $error("debounce did not extend the sourcing time");
    end
endmodule : lsp_poll_sched

// ---- verilog/lsp_regs.sv ----
`timescale 1ns/1ps
// Operation
// RL1 - A channel with its slow bit clear is polled in low power mode on every base tick.
// RL2 - A channel with its slow bit set is polled on one base tick of four.
// RL3 - A programmable channel with debounce clear is judged by voltage difference with no extra sourcing.
// RL4 - A programmable channel with debounce set keeps sourcing 1.2 ms longer and is judged on final voltage.
// RL5 - Programmable slow register at address 0x18 holds channels 0 to 11, cleared at reset.
// RL6 - Ground slow register at 0x19 holds bits 0 to 14 and 16 to 20, cleared at reset.
// RL7 - Programmable debounce register at 0x1a holds channels 0 to 11, cleared at reset.
// RL8 - Each response word carries fault status in bit 23 and the interrupt flag in bit 22.
// RL9 - A frame carries address in bits 31 to 25, write select in bit 24 and data in bits 23 to 0.
module lsp_regs
    import lsp_pkg::*;
#(
    parameter int POLL_ON_CYC = POLL_ON_CYC_DEF,
    parameter int DEB_CYC     = DEB_CYC_DEF
) (
    input  wire logic                ref_clk_i,          // 125 MHz clock
    input  wire logic                nrst_i,             // Async reset, low
    input  wire logic                spi_cs_n_i,         // Chip select, low
    input  wire logic                spi_sclk_i,         // Serial clock pin
    input  wire logic                spi_mosi_i,         // Serial data in
    output logic                     spi_miso_o,         // Serial data out
    output logic                     spi_miso_oe_n_o,    // Drive enable, low
    input  wire logic                fault_status_i,     // Fault summary
    input  wire logic                interrupt_flag_i,   // Interrupt flag
    input  wire logic                low_power_mode_i,   // Low power active
    input  wire logic                poll_tick_i,        // Base polling tick
    output logic [NUM_CH-1:0]        poll_strobe_o,      // Poll pulse per channel
    output logic [NUM_PROG-1:0]      prog_source_o,      // Polling current on
    output logic [NUM_PROG-1:0]      prog_final_judge_o  // Final voltage judge
);
    lsp_cfg_if cfg_if ();

    // Pin synchronisers
    logic cs_s1_reg, cs_s2_reg, cs_d_reg;
    logic sck_s1_reg, sck_s2_reg, sck_d_reg;
    logic mosi_s1_reg, mosi_s2_reg;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {cs_s1_reg, cs_s2_reg, cs_d_reg}    <= 3'h7;
            {sck_s1_reg, sck_s2_reg, sck_d_reg} <= 3'h0;
            {mosi_s1_reg, mosi_s2_reg}          <= 2'h0;
        end else begin
            {cs_s1_reg, cs_s2_reg, cs_d_reg}    <= {spi_cs_n_i, cs_s1_reg, cs_s2_reg};
            {sck_s1_reg, sck_s2_reg, sck_d_reg} <= {spi_sclk_i, sck_s1_reg, sck_s2_reg};
            {mosi_s1_reg, mosi_s2_reg}          <= {spi_mosi_i, mosi_s1_reg};
        end
    end

    logic frame_start, frame_end, sck_rise, sck_fall;
    assign frame_start = cs_d_reg && !cs_s2_reg;
    assign frame_end   = !cs_d_reg && cs_s2_reg;
    assign sck_rise    = !cs_s2_reg && sck_s2_reg && !sck_d_reg;
    assign sck_fall    = !cs_s2_reg && !sck_s2_reg && sck_d_reg;

    // Receive shifter and bit counter
    logic [FRAME_BITS-1:0] rx_reg;
    logic [BIT_CNT_W-1:0]  cnt_reg;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_reg  <= '0;
            cnt_reg <= '0;
        end else if (frame_start) begin
            cnt_reg <= '0;
        end else if (sck_rise) begin
            rx_reg <= {rx_reg[FRAME_BITS-2:0], mosi_s2_reg};
            if (cnt_reg != FRAME_OVER) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    // Decode of a complete frame
    logic                  frame_ok;
    logic [6:0]            rx_addr;
    logic [DATA_W-1:0]     rx_data;
    assign frame_ok = frame_end && (cnt_reg == FRAME_LEN);
    assign rx_addr  = rx_reg[ADDR_MSB:ADDR_LSB];                     // RL9
    assign rx_data  = rx_reg[DATA_W-1:0];                            // RL9
    logic wr_en;
    assign wr_en    = frame_ok && (rx_reg[RW_BIT] == RW_WRITE);      // RL9

    // Configuration registers
    logic [DATA_W-1:0] slow_prog_reg, slow_gnd_reg, deb_prog_reg;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slow_prog_reg <= RESET_VAL;                              // RL5
            slow_gnd_reg  <= RESET_VAL;                              // RL6
            deb_prog_reg  <= RESET_VAL;                              // RL7
        end else if (wr_en) begin
            case (rx_addr)
                ADDR_SLOW_PROG: slow_prog_reg <= rx_data & MASK_PROG; // RL5
                ADDR_SLOW_GND:  slow_gnd_reg  <= rx_data & MASK_GND;  // RL6
                ADDR_DEB_PROG:  deb_prog_reg  <= rx_data & MASK_PROG; // RL7
                default: ;
            endcase
        end
    end
    assign cfg_if.slow_prog = slow_prog_reg[NUM_PROG-1:0];
    assign cfg_if.slow_gnd  = slow_gnd_reg[NUM_GND-1:0];
    assign cfg_if.deb_prog  = deb_prog_reg[NUM_PROG-1:0];

    // Address of the last complete command selects the next answer
    logic [6:0] last_addr_reg;
    logic       last_rw_reg;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_addr_reg <= '0;
            last_rw_reg   <= 1'b0;
        end else if (frame_ok) begin
            last_addr_reg <= rx_addr;
            last_rw_reg   <= rx_reg[RW_BIT];
        end
    end

    // Read data mux, zero for unmapped addresses
    logic [DATA_W-1:0] rd_data;
    always_comb begin
        case (last_addr_reg)
            ADDR_SLOW_PROG: rd_data = slow_prog_reg;
            ADDR_SLOW_GND:  rd_data = slow_gnd_reg;
            ADDR_DEB_PROG:  rd_data = deb_prog_reg;
            default:        rd_data = RESET_VAL;
        endcase
    end

    // Transmit shifter, loaded at frame start, shifted on falling clock
    logic [FRAME_BITS-1:0] tx_reg;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_reg <= '0;
        end else if (frame_start) begin
            tx_reg <= {last_addr_reg, last_rw_reg, fault_status_i, interrupt_flag_i,
                       rd_data[RESP_DATA_W-1:0]};                    // RL8
        end else if (sck_fall) begin
            tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
        end
    end

    // Output pin registers
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            spi_miso_o      <= 1'b0;
            spi_miso_oe_n_o <= 1'b1;
        end else begin
            spi_miso_o      <= tx_reg[FRAME_BITS-1];
            spi_miso_oe_n_o <= cs_s2_reg;
        end
    end

    lsp_poll_sched #(
        .POLL_ON_CYC (POLL_ON_CYC),
        .DEB_CYC     (DEB_CYC)
    ) u_sched (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .cfg       (cfg_if.sched),
        .lpm_i     (low_power_mode_i),
        .tick_i    (poll_tick_i),
        .poll_o    (poll_strobe_o),
        .source_o  (prog_source_o),
        .final_o   (prog_final_judge_o)
    );

    a_write_prog: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL5
        wr_en && rx_addr == ADDR_SLOW_PROG |=> slow_prog_reg == ($past(rx_data) & MASK_PROG))
        else $error("programmable slow register not written");
    a_gnd_gap_bit: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL6
        slow_gnd_reg[15] == 1'b0 && slow_gnd_reg[DATA_W-1:NUM_GND] == '0)
        else $error("ground slow register holds an unused bit");
    a_deb_upper: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL7
        deb_prog_reg[DATA_W-1:NUM_PROG] == '0)
        else $error("debounce register holds an unused bit");
    a_resp_flags: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL8
        frame_start |=> tx_reg[FAULT_BIT] == $past(fault_status_i)
                        && tx_reg[INT_BIT] == $past(interrupt_flag_i))
        else $error("response flags not loaded");
    a_short_frame: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL9
        frame_end && cnt_reg != FRAME_LEN |=> $stable(slow_prog_reg) && $stable(slow_gnd_reg)
                                              && $stable(deb_prog_reg))
        else $error("frame of wrong length changed a register");
    a_miso_release: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        cs_s2_reg |=> spi_miso_oe_n_o)
        else $error("data out driven outside a frame");
    // Register write, frame decode and answer checks
    a_write_gnd: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL6
        wr_en && rx_addr == ADDR_SLOW_GND |=> slow_gnd_reg == ($past(rx_data) & MASK_GND))
        else $error("ground slow register not written");
    a_write_deb: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL7
        wr_en && rx_addr == ADDR_DEB_PROG |=> deb_prog_reg == ($past(rx_data) & MASK_PROG))
        else $error("debounce register not written");
    a_prog_upper: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL5
        slow_prog_reg[DATA_W-1:NUM_PROG] == '0)
        else $error("programmable slow register holds an unused bit");
    a_read_keeps: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL9
        frame_ok && rx_reg[RW_BIT] != RW_WRITE |=> $stable(slow_prog_reg) && $stable(slow_gnd_reg)
                                                   && $stable(deb_prog_reg))
        else $error("read frame changed a register");
    a_addr_latch: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL9
        frame_ok |=> last_addr_reg == $past(rx_addr) && last_rw_reg == $past(rx_reg[RW_BIT]))
        else $error("command address not kept for the answer");
    a_resp_data: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL8
        frame_start |=> tx_reg[RESP_DATA_W-1:0] == $past(rd_data[RESP_DATA_W-1:0]))
        else $error("response data not loaded");
    a_count_cap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RL9
        cnt_reg <= FRAME_OVER)
        else $error("bit counter ran past its cap");
    a_miso_drive: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !cs_s2_reg |=> !spi_miso_oe_n_o)
        else $error("data out not driven inside a frame");

    c_write_gnd: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_en && rx_addr == ADDR_SLOW_GND);
    c_read_deb: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        frame_start && last_addr_reg == ADDR_DEB_PROG && !last_rw_reg);
    c_slow_poll: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        low_power_mode_i && poll_tick_i && cfg_if.slow_prog[0]);
    c_short_frame: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        frame_end && cnt_reg != FRAME_LEN);
    c_deb_poll: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
        low_power_mode_i && poll_tick_i && cfg_if.deb_prog[0]);
endmodule : lsp_regs
